// File: ubrg_pkg.sv
/*
  Package for the serial baud rate generator: register map, field layout,
  reset values and clock-source encodings.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
`default_nettype none
package ubrg_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] DIV_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  // ==========================================================
  // Field positions
  localparam int SRC_LSB  = 0;
  localparam int SYNC_BIT = 4;
  localparam int OVER_BIT = 5;
  localparam int NORM_BIT = 6;
  localparam int FP_LSB   = 16;
  // ==========================================================
  // Clock sources, pre-divider and oversampling counts
  localparam logic [1:0] SRC_MCK  = 2'h0;
  localparam logic [1:0] SRC_DIV  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h3;
  localparam logic [3:0] PRE_DIV  = 4'h8;
  localparam logic [3:0] PRE_LAST = 4'h7;
  localparam logic [3:0] OVS8_LAST  = 4'h7;
  localparam logic [3:0] OVS16_LAST = 4'hf;
  // ==========================================================
  // Reset values
  localparam logic [15:0] DIV_RST  = 16'h0000;
  localparam logic [2:0]  FP_RST   = 3'h0;
  localparam logic [6:0]  MODE_RST = 7'h40;
  // ==========================================================
  // Configuration carrier
  typedef struct packed {
    logic        normal;
    logic        over;
    logic        sync;
    logic [1:0]  src;
    logic [2:0]  fp;
    logic [15:0] cd;
  } ubrg_cfg_t;
endpackage
`default_nettype wire

// File: ubrg_top.sv
/*
  Baud rate generator: clock source select, 16-bit divider with eighth
  fractional step, oversampling divider, Wishbone register slave.
  Assumes a synchronous reset, one clock, and an external serial clock
  slower than a quarter of the master clock.
*/
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ubrg_top (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // Peripheral clock gate
  input  wire logic        CLK_EN,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Serial clock pin
  input  wire logic        SCK_I,
  // Baud outputs
  output logic             SAMPLE_TICK,
  output logic             BIT_TICK
);
  // ==========================================================
  // Declarations
  ubrg_pkg::ubrg_cfg_t cfg_r;
  ubrg_pkg::ubrg_cfg_t act_r;
  logic        sck_s1_r;
  logic        sck_s2_r;
  logic        sck_s3_r;
  logic [3:0]  pre_cnt_r;
  logic        src_tick;
  logic        pre_tick;
  logic        ext_tick;
  logic [15:0] div_cnt_r;
  logic [2:0]  frac_acc_r;
  logic        extra_r;
  logic        div_tick;
  logic [15:0] reload_nxt;
  logic [2:0]  frac_sum;
  logic        frac_carry;
  logic        sample_nxt;
  logic [3:0]  ovs_cnt_r;
  logic [3:0]  ovs_last;
  logic        wb_hit;
  logic [31:0] rd_nxt;
  logic        idle_load;

  // ==========================================================
  // Helper functions
  // Byte lane merge for writes
  function automatic logic [7:0] lane(input logic [31:0] d,
                                      input logic [7:0]  q,
                                      input logic [3:0]  s,
                                      input int          n);
    lane = s[n] ? d[8*n +: 8] : q;
  endfunction

  // Register offset match
  function automatic logic ofs_hit(input logic [7:0] a,
                                   input logic [7:0] o);
    ofs_hit = (a == o);
  endfunction

  // Last source tick of a divider period
  function automatic logic period_end(input logic [15:0] c,
                                      input logic        x);
    period_end = (c == 16'h0001) && !x;
  endfunction

  // Fraction step in normal asynchronous mode only
  function automatic logic frac_on(input ubrg_pkg::ubrg_cfg_t c);
    frac_on = c.normal && !c.sync && (c.fp != 3'h0);
  endfunction

  // Small counter at or past its last value
  function automatic logic cnt_wrap(input logic [3:0] c,
                                    input logic [3:0] l);
    cnt_wrap = (c >= l);
  endfunction

  // Mode word as read back
  function automatic logic [31:0] mode_word(input ubrg_pkg::ubrg_cfg_t c);
    mode_word = 32'h0000_0000;
    mode_word[ubrg_pkg::SRC_LSB +: 2] = c.src;
    mode_word[ubrg_pkg::SYNC_BIT]     = c.sync;
    mode_word[ubrg_pkg::OVER_BIT]     = c.over;
    mode_word[ubrg_pkg::NORM_BIT]     = c.normal;
  endfunction

  // Status word: divider count, oversample count, stretch flag
  function automatic logic [31:0] status_word(input logic [15:0] c,
                                              input logic [3:0]  o,
                                              input logic        x);
    status_word = {11'h000, x, o, c};
  endfunction

  // ==========================================================
  // Register slave
  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // Writes need no peripheral clock enable
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cfg_r.src    <= ubrg_pkg::MODE_RST[ubrg_pkg::SRC_LSB +: 2];
      cfg_r.sync   <= ubrg_pkg::MODE_RST[ubrg_pkg::SYNC_BIT];
      cfg_r.over   <= ubrg_pkg::MODE_RST[ubrg_pkg::OVER_BIT];
      cfg_r.normal <= ubrg_pkg::MODE_RST[ubrg_pkg::NORM_BIT];
      cfg_r.fp <= ubrg_pkg::FP_RST;
      cfg_r.cd <= ubrg_pkg::DIV_RST;
    end else if (wb_hit && WB_WE_I) begin
      if (ofs_hit(WB_ADR_I, ubrg_pkg::MODE_OFS)) begin
        if (WB_SEL_I[0]) begin
          cfg_r.src    <= WB_DAT_I[ubrg_pkg::SRC_LSB +: 2];
          cfg_r.sync   <= WB_DAT_I[ubrg_pkg::SYNC_BIT];
          cfg_r.over   <= WB_DAT_I[ubrg_pkg::OVER_BIT];
          cfg_r.normal <= WB_DAT_I[ubrg_pkg::NORM_BIT];
        end
      end else if (ofs_hit(WB_ADR_I, ubrg_pkg::DIV_OFS)) begin
        cfg_r.cd[7:0]  <= lane(WB_DAT_I, cfg_r.cd[7:0], WB_SEL_I, 0);
        cfg_r.cd[15:8] <= lane(WB_DAT_I, cfg_r.cd[15:8], WB_SEL_I, 1);
        if (WB_SEL_I[2]) begin
          cfg_r.fp <= WB_DAT_I[ubrg_pkg::FP_LSB +: 3];
        end
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (ofs_hit(WB_ADR_I, ubrg_pkg::MODE_OFS)) begin
      rd_nxt = mode_word(cfg_r);
    end else if (ofs_hit(WB_ADR_I, ubrg_pkg::DIV_OFS)) begin
      rd_nxt[15:0] = cfg_r.cd;
      rd_nxt[ubrg_pkg::FP_LSB +: 3] = cfg_r.fp;
    end else if (ofs_hit(WB_ADR_I, ubrg_pkg::STATUS_OFS)) begin
      rd_nxt = status_word(div_cnt_r, ovs_cnt_r, extra_r);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= wb_hit ? rd_nxt : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Clock source selection
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
    end else begin
      sck_s1_r <= SCK_I;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
    end
  end
  // Rising edge of pin, valid given slow phases
  assign ext_tick = sck_s2_r && !sck_s3_r;

  // Fixed pre-divider, frozen while clock gated
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pre_cnt_r <= 4'h0;
    end else if (CLK_EN) begin
      pre_cnt_r <= cnt_wrap(pre_cnt_r, ubrg_pkg::PRE_LAST) ? 4'h0
                                                          : pre_cnt_r + 4'h1;
    end
  end
  assign pre_tick = cnt_wrap(pre_cnt_r, ubrg_pkg::PRE_LAST);

  always_comb begin
    if (act_r.src == ubrg_pkg::SRC_MCK) begin
      src_tick = CLK_EN;
    end else if (act_r.src == ubrg_pkg::SRC_DIV) begin
      src_tick = CLK_EN && pre_tick;
    end else if (act_r.src == ubrg_pkg::SRC_EXT) begin
      src_tick = CLK_EN && ext_tick;
    end else begin
      src_tick = 1'b0;
    end
  end

  // ==========================================================
  // Divider with fractional step
  assign frac_sum   = frac_acc_r + act_r.fp;
  assign frac_carry = ({1'b0, frac_acc_r} + {1'b0, act_r.fp}) > 4'h7;
  assign div_tick   = src_tick && period_end(div_cnt_r, extra_r);
  assign idle_load  = (div_cnt_r == 16'h0000) || (act_r.cd == 16'h0000);

  always_comb begin
    reload_nxt = cfg_r.cd;
  end

  // Active configuration swaps only at a reload point
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      act_r <= '0;
    end else if (idle_load || div_tick) begin
      act_r <= cfg_r;
    end
  end

  // Period counter parks at the load point for a zero divisor
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      div_cnt_r <= 16'h0000;
    end else if (idle_load || div_tick) begin
      div_cnt_r <= reload_nxt;
    end else if (src_tick && !extra_r) begin
      div_cnt_r <= div_cnt_r - 16'h0001;
    end
  end

  // ==========================================================
  // Fractional stretch
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      frac_acc_r <= 3'h0;
      extra_r    <= 1'b0;
    end else if (idle_load) begin
      frac_acc_r <= 3'h0;
      extra_r    <= 1'b0;
    end else if (src_tick && extra_r) begin
      extra_r <= 1'b0; // Stretch cycle of divisor plus one
    end else if (div_tick && frac_on(act_r)) begin
      frac_acc_r <= frac_sum;
      extra_r    <= frac_carry && (reload_nxt != 16'h0000);
    end else if (div_tick) begin
      frac_acc_r <= 3'h0;
    end
  end

  // ==========================================================
  // Baud outputs
  always_comb begin
    if (act_r.sync && act_r.src == ubrg_pkg::SRC_EXT) begin
      sample_nxt = src_tick; // Pin used directly
    end else if (act_r.cd == 16'h0000) begin
      sample_nxt = 1'b0;
    end else if (act_r.cd == 16'h0001) begin
      sample_nxt = src_tick; // Bypass
    end else begin
      sample_nxt = div_tick;
    end
  end

  // ==========================================================
  // Oversampling divider
  assign ovs_last = act_r.over ? ubrg_pkg::OVS8_LAST
                               : ubrg_pkg::OVS16_LAST;

  // Counts sampling ticks in asynchronous mode
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ovs_cnt_r <= 4'h0;
    end else if (sample_nxt && !act_r.sync) begin
      ovs_cnt_r <= cnt_wrap(ovs_cnt_r, ovs_last) ? 4'h0 : ovs_cnt_r + 4'h1;
    end
  end

  // One bit clock shared by receiver and transmitter
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SAMPLE_TICK <= 1'b0;
      BIT_TICK    <= 1'b0;
    end else begin
      SAMPLE_TICK <= sample_nxt;
      BIT_TICK    <= sample_nxt && (act_r.sync || cnt_wrap(ovs_cnt_r, ovs_last));
    end
  end
endmodule // ubrg_top
`default_nettype wire

// File: ubrg_sva.sv
/* Port checker for the baud rate generator.
   Assumes full-word bus writes and one clock. */
`timescale 1ns/1ns
`default_nettype none
module ubrg_chk (
  // Clock, reset, gate, bus
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        CLK_EN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Ticks
  input wire logic        SAMPLE_TICK,
  input wire logic        BIT_TICK
);
  logic [15:0] cd_r, cdp_r;
  logic [2:0]  fp_r;
  logic [6:0]  md_r;
  int          st_r, sg_r, bg_r, lim;
  logic        wr;
  logic [1:0]  src;
  assign wr  = WB_ACK_O && WB_WE_I;
  assign src = md_r[1:0];
  assign lim = 32 * (cd_r + cdp_r) + 16;
  // ==========================================================
  // Shadow configuration and tick spacing
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cd_r  <= ubrg_pkg::DIV_RST;
      cdp_r <= ubrg_pkg::DIV_RST;
      fp_r  <= ubrg_pkg::FP_RST;
      md_r  <= ubrg_pkg::MODE_RST;
    end else if (wr && WB_ADR_I == ubrg_pkg::DIV_OFS) begin
      cdp_r <= cd_r;
      cd_r  <= WB_DAT_I[15:0];
      fp_r  <= WB_DAT_I[18:16];
    end else if (wr && WB_ADR_I == ubrg_pkg::MODE_OFS) begin
      md_r  <= WB_DAT_I[6:0];
    end
  end
  always_ff @(posedge MCLK) begin
    st_r <= (!RST_N || wr || !CLK_EN) ? 0 : st_r + 1;
    sg_r <= (!RST_N || SAMPLE_TICK) ? 0 : sg_r + int'(CLK_EN);
    bg_r <= (!RST_N || BIT_TICK) ? 0 : bg_r + int'(CLK_EN);
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_pulse; WB_ACK_O ##1 !WB_ACK_O; endsequence
  property p_ack; s_req |=> s_pulse; endproperty
  property p_idle; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
  property p_dat; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  property p_frz;
    !CLK_EN && $past(!CLK_EN) |-> !$rose(SAMPLE_TICK) && !$rose(BIT_TICK);
  endproperty
  property p_zero;
    cd_r == 16'h0 && src != ubrg_pkg::SRC_EXT && st_r > lim |-> !SAMPLE_TICK;
  endproperty
  property p_div;
    SAMPLE_TICK && src == ubrg_pkg::SRC_MCK && fp_r == 3'h0 && st_r > lim
      |-> sg_r + 1 == cd_r;
  endproperty
  property p_pre;
    SAMPLE_TICK && src == ubrg_pkg::SRC_DIV && fp_r == 3'h0 && st_r > lim
      |-> sg_r + 1 == 8 * cd_r;
  endproperty
  property p_bit;
    BIT_TICK && src == ubrg_pkg::SRC_MCK && !md_r[ubrg_pkg::SYNC_BIT]
      && fp_r == 3'h0 && st_r > lim
      |-> bg_r + 1 == cd_r * (md_r[ubrg_pkg::OVER_BIT] ? 8 : 16);
  endproperty
  property p_sync;
    md_r[ubrg_pkg::SYNC_BIT] && src == ubrg_pkg::SRC_EXT && st_r > lim
      |-> BIT_TICK == SAMPLE_TICK;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  a_idle: assert property (p_idle) else $error("ack without request");
  a_dat: assert property (p_dat) else $error("data without ack");
  a_frz: assert property (p_frz) else $error("tick while frozen");
  a_zero: assert property (p_zero) else $error("tick at zero");
  a_div: assert property (p_div) else $error("sample gap");
  a_pre: assert property (p_pre) else $error("prescaled gap");
  a_bit: assert property (p_bit) else $error("bit gap");
  a_sync: assert property (p_sync) else $error("sync tick");
endmodule // ubrg_chk
bind ubrg_top ubrg_chk u_chk (.MCLK(MCLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .SAMPLE_TICK(SAMPLE_TICK), .BIT_TICK(BIT_TICK));
`default_nettype wire

// File: ubrg_sck_dev.sv
/* Remote device driving the serial clock pin.
   Assumes the bench frames its activity with run. */
`timescale 1ns/1ns
`default_nettype none
module ubrg_sck_dev #(
  parameter int HALF = 37
) (
  // Frame control and pin
  input  wire logic run,
  output logic      sck
);
  // ==========================================================
  // Clock only inside a frame, idle low
  initial sck = 1'b0;
  always begin
    wait (run);
    #HALF sck = 1'b1;
    #HALF sck = 1'b0;
  end
endmodule // ubrg_sck_dev
`default_nettype wire

// File: tb_usart_baud_rate_generator.sv
/* Testbench for the baud rate generator.
   Assumes the checker is bound and the far device model is present. */
`timescale 1ns/1ns
`default_nettype none
module tb_usart_baud_rate_generator;
  logic        mclk = 0, rst_n = 0, clk_en = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dat = 32'h0, dat_o, rs = 32'h8e0e;
  logic        ack, stk, btk, sck, run = 0;
  logic [31:0] q[$];
  int          errors = 0, checks = 0, cd, n, e = 0;
  always #5 mclk = ~mclk;
  always @(posedge sck) e++;
  ubrg_top dut (.MCLK(mclk), .RST_N(rst_n), .CLK_EN(clk_en),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .SCK_I(sck), .SAMPLE_TICK(stk), .BIT_TICK(btk));
  ubrg_sck_dev far (.run(run), .sck(sck));
  // ==========================================================
  // Reporting and bus tasks
  task automatic end_sim();
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic cmp_dat(input logic [31:0] g, x);
    checks++;
    if (g !== x) bad("read data");
  endtask
  task automatic cmp_cnt(input int g, x);
    checks++;
    if (g != x) bad("tick spacing");
  endtask
  function automatic int rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return int'(rs[2:0]);
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
    do @(posedge mclk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic cfg(input logic [6:0] m, input int c, input logic [2:0] f);
    wb(1'b1, ubrg_pkg::MODE_OFS, {25'h0, m});
    wb(1'b1, ubrg_pkg::DIV_OFS, {13'h0, f, c[15:0]});
    repeat (600) @(posedge mclk);
  endtask
  task automatic meas(input logic b, input int k, f, x);
    int t = 0;
    int c = -1;
    while (c < k) begin
      @(posedge mclk);
      if (c >= 0) t++;
      if ((b ? btk : stk) === 1'b1) begin
        c++;
        if (c == 0 && f > 0) begin
          clk_en <= 1'b0;
          repeat (f) @(posedge mclk);
          clk_en <= 1'b1;
          t = f;
        end
      end
    end
    cmp_cnt(t, x);
  endtask
  task automatic count_ticks(input int w);
    n = 0;
    repeat (w) begin
      @(posedge mclk);
      if (stk === 1'b1) n++;
    end
  endtask
  // ==========================================================
  // Read monitor and watchdog
  always @(posedge mclk)
    if (ack === 1'b1 && !we) cmp_dat(dat_o, q.pop_front());
  initial begin
    repeat (50000) @(posedge mclk);
    bad("timeout");
    end_sim();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ubrg_pkg::MODE_OFS, {25'h0, ubrg_pkg::MODE_RST});
    rd(ubrg_pkg::DIV_OFS, 32'h0);
    rd(8'h0c, 32'h0);
    clk_en <= 1'b1;
    count_ticks(100);
    cmp_cnt(n, 0);
    clk_en <= 1'b0;
    cd = 2 + rnd();
    wb(1'b1, ubrg_pkg::DIV_OFS, 32'(cd));
    rd(ubrg_pkg::DIV_OFS, 32'(cd));
    clk_en <= 1'b1;
    repeat (600) @(posedge mclk);
    meas(1'b0, 4, 0, 4 * cd);
    meas(1'b1, 2, 0, 32 * cd);
    cfg(7'h60, cd, 3'h0);
    meas(1'b1, 2, 0, 16 * cd);
    meas(1'b0, 1, 20, cd + 20);
    cfg(7'h40, 1, 3'h0);
    meas(1'b0, 4, 0, 4);
    cfg(7'h41, 2, 3'h0);
    meas(1'b0, 2, 0, 32);
    cfg(7'h40, cd, 3'h3);
    meas(1'b0, 8, 0, 8 * cd + 3);
    cfg(7'h00, cd, 3'h3);
    meas(1'b0, 8, 0, 8 * cd);
    cfg(7'h53, 0, 3'h0);
    e = 0;
    run <= 1'b1;
    fork
      count_ticks(400);
      begin
        repeat (150) @(posedge mclk);
        run <= 1'b0;
      end
    join
    cmp_cnt(n, e);
    end_sim();
  end
endmodule // tb_usart_baud_rate_generator
`default_nettype wire
